// ===== src/uart_shadow_data_path.sv
// Functional notes
// [R1] receive buffer readable via sixteen alias words
// [R2] read returns received byte in bits 7:0
// [R3] data valid only while data-ready set
// [R4] queues off: new byte overwrites, flag overrun
// [R5] queues on: alias read returns queue head
// [R6] full receive queue drops new byte, overrun
// [R7] holding register writable via same alias words
// [R8] written bytes go to serial or infrared output
// [R9] master writes only while holding-empty set
// [R10] queues off: single write clears holding-empty
// [R11] queues off: further write replaces pending byte
// [R12] queues on: sixteen writes before queue full
// [R13] writes to full transmit queue are discarded
// [R14] bits 15:8 read zero, writes ignored
`timescale 1ns/1ps
module uart_shadow_data_path
  import uart_shadow_pkg::*;
(
  input  wire logic        REF_CLK_IN,
  input  wire logic        SRST_IN,
  input  wire logic        WB_CYC_IN,
  input  wire logic        WB_STB_IN,
  input  wire logic        WB_WE_IN,
  input  wire logic [31:0] WB_ADR_IN,
  input  wire logic [3:0]  WB_SEL_IN,
  input  wire logic [31:0] WB_DAT_IN,
  output logic      [31:0] WB_DAT_OUT,
  output logic             WB_ACK_OUT,
  output logic             WB_ERR_OUT,
  input  wire logic        TX_TAKE_IN,
  output logic             TX_VALID_OUT,
  output logic      [7:0]  TX_DATA_OUT,
  output logic             TX_IR_OUT,
  output logic             DATA_READY_OUT,
  output logic             HOLD_EMPTY_OUT
);

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic        req;          // new access, not yet answered
  logic        is_shadow;    // address in the alias window
  logic        is_ctrl;      // control word
  logic        is_stat;      // status word
  logic        is_inject;    // receive byte entry word
  logic        hit;          // any mapped word
  logic        wr_lo;        // write with byte lane 0 enabled
  logic        rd_shadow;    // alias read taken this cycle
  logic        wr_shadow;    // alias write taken this cycle
  logic        rx_arrive;    // received byte arrives
  logic [7:0]  rx_byte;      // the arriving byte

  assign req       = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT && !WB_ERR_OUT;
  // [R1] sixteen aligned alias words
  assign is_shadow = (WB_ADR_IN >= SHADOW_BASE_ADDR) && (WB_ADR_IN <= SHADOW_LAST_ADDR)
                     && (WB_ADR_IN[1:0] == 2'h0);
  assign is_ctrl   = (WB_ADR_IN == CONTROL_ADDR);
  assign is_stat   = (WB_ADR_IN == STATUS_ADDR);
  assign is_inject = (WB_ADR_IN == RX_INJECT_ADDR);
  assign hit       = is_shadow || is_ctrl || is_stat || is_inject;
  assign wr_lo     = req && WB_WE_IN && WB_SEL_IN[0];
  assign rd_shadow = req && !WB_WE_IN && is_shadow;
  // [R7] same alias words take writes
  assign wr_shadow = wr_lo && is_shadow;
  assign rx_arrive = wr_lo && is_inject;
  assign rx_byte   = WB_DAT_IN[7:0];

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  logic queue_en;   // queue control bit 0
  logic ir_mode;    // infrared mode select
  logic mode_flip;  // queue enable changes: flush queues

  assign mode_flip = wr_lo && is_ctrl && (WB_DAT_IN[CTRL_QUEUE_EN_BIT] != queue_en);

  // software writes queue enable and infrared mode
  always_ff @(posedge REF_CLK_IN)
  begin
    if (SRST_IN)
    begin
      queue_en <= 1'b0;
      ir_mode  <= 1'b0;
    end
    else if (wr_lo && is_ctrl)
    begin
      queue_en <= WB_DAT_IN[CTRL_QUEUE_EN_BIT];
      ir_mode  <= WB_DAT_IN[CTRL_IR_MODE_BIT];
    end
  end

  // ---------------------------------------------------------------
  // receive side
  // ---------------------------------------------------------------
  logic       [7:0] rx_buffer_register; // single buffer, queues off
  logic             single_ready;       // single buffer holds a byte
  logic             rxq_empty;          // receive queue empty
  logic             rxq_full;           // receive queue full
  logic       [7:0] rxq_head;           // receive queue head
  logic             overrun;            // sticky overrun error
  logic             data_ready_flag;    // line state data ready
  byte_beat_t       rxq_push;           // byte into receive queue
  logic             rxq_pop;            // head consumed

  assign rxq_push.valid = rx_arrive && queue_en;
  assign rxq_push.data  = rx_byte;
  // [R5] alias read pops the queue head
  assign rxq_pop        = rd_shadow && queue_en;
  // [R3] valid only while this flag is set
  assign data_ready_flag = queue_en ? !rxq_empty : single_ready;

  uart_byte_queue rx_queue
  (
    .clk_in    (REF_CLK_IN),
    .rst_in    (SRST_IN),
    .flush_in  (mode_flip),
    .push_in   (rxq_push),
    .pop_in    (rxq_pop),
    .head_out  (rxq_head),
    .empty_out (rxq_empty),
    .full_out  (rxq_full)
  );

  // single receive buffer, queues disabled
  always_ff @(posedge REF_CLK_IN)
  begin
    if (SRST_IN || mode_flip)
    begin
      rx_buffer_register <= DATA_RESET;
      single_ready       <= 1'b0;
    end
    else if (rx_arrive && !queue_en)
    begin
      // [R4] new byte overwrites unread one
      rx_buffer_register <= rx_byte;
      single_ready       <= 1'b1;
    end
    else if (rd_shadow)
    begin
      single_ready <= 1'b0;
    end
  end

  // overrun: set wins over the clear by status read
  always_ff @(posedge REF_CLK_IN)
  begin
    if (SRST_IN)
    begin
      overrun <= 1'b0;
    end
    // [R4] overwrite of unread byte
    else if (rx_arrive && !queue_en && single_ready && !rd_shadow)
    begin
      overrun <= 1'b1;
    end
    // [R6] full queue drops the arrival
    else if (rx_arrive && queue_en && rxq_full)
    begin
      overrun <= 1'b1;
    end
    else if (req && !WB_WE_IN && is_stat)
    begin
      overrun <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // transmit side
  // ---------------------------------------------------------------
  logic       [7:0] tx_hold_register; // single holding register
  logic             hold_full;        // holding register loaded
  logic             txq_empty;        // transmit queue empty
  logic             txq_full;         // transmit queue full
  logic       [7:0] txq_head;         // transmit queue head
  logic             tx_hold_empty_flag; // line state bit 5
  byte_beat_t       txq_push;         // byte into transmit queue
  logic             tx_taken;         // shifter takes the byte
  logic             next_tx_valid;    // byte pending for shifter
  logic       [7:0] next_tx_data;     // byte offered to shifter

  // [R12] sixteen entries accepted; [R13] full drops in queue
  assign txq_push.valid = wr_shadow && queue_en;
  assign txq_push.data  = WB_DAT_IN[7:0];
  assign tx_hold_empty_flag = queue_en ? txq_empty : !hold_full;
  assign next_tx_valid  = queue_en ? !txq_empty : hold_full;
  assign next_tx_data   = queue_en ? txq_head : tx_hold_register;
  assign tx_taken       = TX_TAKE_IN && TX_VALID_OUT;

  uart_byte_queue tx_queue
  (
    .clk_in    (REF_CLK_IN),
    .rst_in    (SRST_IN),
    .flush_in  (mode_flip),
    .push_in   (txq_push),
    .pop_in    (tx_taken && queue_en),
    .head_out  (txq_head),
    .empty_out (txq_empty),
    .full_out  (txq_full)
  );

  // single holding register, queues disabled
  always_ff @(posedge REF_CLK_IN)
  begin
    if (SRST_IN || mode_flip)
    begin
      tx_hold_register <= DATA_RESET;
      hold_full        <= 1'b0;
    end
    else if (wr_shadow && !queue_en)
    begin
      // [R10] write clears holding-empty; [R11] overwrite pending
      tx_hold_register <= WB_DAT_IN[7:0];
      hold_full        <= 1'b1;
    end
    else if (tx_taken)
    begin
      hold_full <= 1'b0;
    end
  end

  // [R8] byte to serial line, infrared select
  always_ff @(posedge REF_CLK_IN)
  begin
    if (SRST_IN)
    begin
      TX_VALID_OUT <= 1'b0;
      TX_DATA_OUT  <= DATA_RESET;
      TX_IR_OUT    <= 1'b0;
    end
    else
    begin
      // drop valid right after a take so a byte is never sent twice
      TX_VALID_OUT <= next_tx_valid && !tx_taken;
      TX_DATA_OUT  <= next_tx_data;
      TX_IR_OUT    <= ir_mode;
    end
  end

  // [R9] master polls this flag before writing
  always_ff @(posedge REF_CLK_IN)
  begin
    if (SRST_IN)
    begin
      DATA_READY_OUT <= 1'b0;
      HOLD_EMPTY_OUT <= 1'b1;
    end
    else
    begin
      DATA_READY_OUT <= data_ready_flag;
      HOLD_EMPTY_OUT <= tx_hold_empty_flag;
    end
  end

  // ---------------------------------------------------------------
  // bus answer
  // ---------------------------------------------------------------
  // one-cycle ack or err, read data registered with it
  always_ff @(posedge REF_CLK_IN)
  begin
    if (SRST_IN)
    begin
      WB_ACK_OUT <= 1'b0;
      WB_ERR_OUT <= 1'b0;
      WB_DAT_OUT <= BUS_READ_ZERO;
    end
    else
    begin
      WB_ACK_OUT <= req && hit;
      WB_ERR_OUT <= req && !hit;
      WB_DAT_OUT <= BUS_READ_ZERO;
      if (req && !WB_WE_IN && is_shadow)
      begin
        // [R2] byte in 7:0; [R14] upper bits zero
        WB_DAT_OUT[7:0] <= queue_en ? rxq_head : rx_buffer_register;
      end
      else if (req && !WB_WE_IN && is_ctrl)
      begin
        WB_DAT_OUT[CTRL_QUEUE_EN_BIT] <= queue_en;
        WB_DAT_OUT[CTRL_IR_MODE_BIT]  <= ir_mode;
      end
      else if (req && !WB_WE_IN && is_stat)
      begin
        WB_DAT_OUT[STAT_DATA_READY_BIT] <= data_ready_flag;
        WB_DAT_OUT[STAT_OVERRUN_BIT]    <= overrun;
        WB_DAT_OUT[STAT_HOLD_EMPTY_BIT] <= tx_hold_empty_flag;
        WB_DAT_OUT[STAT_TX_FULL_BIT]    <= txq_full;
        WB_DAT_OUT[STAT_RX_FULL_BIT]    <= rxq_full;
      end
    end
  end

endmodule

// ===== inc/uart_shadow_pkg.sv
package uart_shadow_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses, 32-bit aligned words)
  // ---------------------------------------------------------------
  localparam logic [31:0] SHADOW_BASE_ADDR  = 32'h5000_1130; // first of sixteen alias words
  localparam logic [31:0] SHADOW_LAST_ADDR  = 32'h5000_116c; // sixteenth alias word
  localparam logic [31:0] CONTROL_ADDR      = 32'h5000_1180; // queue enable, infrared mode
  localparam logic [31:0] STATUS_ADDR       = 32'h5000_1184; // line state flags
  localparam logic [31:0] RX_INJECT_ADDR    = 32'h5000_1188; // byte from receiver framing

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CTRL_QUEUE_EN_BIT  = 0;
  localparam int CTRL_IR_MODE_BIT   = 1;
  localparam int STAT_DATA_READY_BIT = 0;
  localparam int STAT_OVERRUN_BIT    = 1;
  localparam int STAT_HOLD_EMPTY_BIT = 5;
  localparam int STAT_TX_FULL_BIT    = 8;
  localparam int STAT_RX_FULL_BIT    = 9;

  // ---------------------------------------------------------------
  // sizes and reset values
  // ---------------------------------------------------------------
  localparam int          QUEUE_DEPTH    = 16;
  localparam int          PTR_W          = 4;
  localparam int          CNT_W          = 5;
  localparam logic [7:0]  DATA_RESET     = 8'h00;
  localparam logic [31:0] BUS_READ_ZERO  = 32'h0000_0000;

  // one byte travelling with its valid strobe
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } byte_beat_t;

endpackage

// ===== src/uart_byte_queue.sv
`timescale 1ns/1ps
module uart_byte_queue
  import uart_shadow_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       flush_in,
  input  wire byte_beat_t push_in,
  input  wire logic       pop_in,
  output logic [7:0]      head_out,
  output logic            empty_out,
  output logic            full_out
);

  // ---------------------------------------------------------------
  // storage and pointers
  // ---------------------------------------------------------------
  logic [7:0]       mem [QUEUE_DEPTH]; // flip-flop storage
  logic [PTR_W-1:0] wr_ptr;            // next slot to fill
  logic [PTR_W-1:0] rd_ptr;            // head slot
  logic [CNT_W-1:0] count;             // entries held
  logic             do_push;           // push that fits
  logic             do_pop;            // pop that has data

  assign empty_out = (count == '0);
  assign full_out  = (count == CNT_W'(QUEUE_DEPTH));
  assign head_out  = mem[rd_ptr];
  // a push into a full queue is dropped, contents untouched
  assign do_push   = push_in.valid && !full_out;
  assign do_pop    = pop_in && !empty_out;

  // write side
  always_ff @(posedge clk_in)
  begin
    if (do_push)
    begin
      mem[wr_ptr] <= push_in.data;
    end
  end

  // pointer and level bookkeeping
  always_ff @(posedge clk_in)
  begin
    if (rst_in || flush_in)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (do_push)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_pop)
      begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (do_push && !do_pop)
      begin
        count <= count + 1'b1;
      end
      else if (do_pop && !do_push)
      begin
        count <= count - 1'b1;
      end
    end
  end

endmodule

// ===== sim/uart_shadow_data_path_checker.sv
`timescale 1ns/1ps
module uart_shadow_checker
  import uart_shadow_pkg::*;
(
  input wire logic        REF_CLK_IN,
  input wire logic        SRST_IN,
  input wire logic        WB_CYC_IN,
  input wire logic        WB_STB_IN,
  input wire logic        WB_WE_IN,
  input wire logic [31:0] WB_ADR_IN,
  input wire logic [3:0]  WB_SEL_IN,
  input wire logic [31:0] WB_DAT_OUT,
  input wire logic        WB_ACK_OUT,
  input wire logic        WB_ERR_OUT,
  input wire logic        TX_TAKE_IN,
  input wire logic        TX_VALID_OUT,
  input wire logic        HOLD_EMPTY_OUT
);
  // -----------------------------
  // helpers
  // -----------------------------
  logic in_alias; // address hits one of the alias words
  assign in_alias = (WB_ADR_IN >= SHADOW_BASE_ADDR) && (WB_ADR_IN <= SHADOW_LAST_ADDR)
                    && (WB_ADR_IN[1:0] == 2'h0);
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (SRST_IN);
  sequence s_req;
    WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT && !WB_ERR_OUT;
  endsequence
  sequence s_alias_wr;
    WB_ACK_OUT && WB_WE_IN && WB_SEL_IN[0] && in_alias;
  endsequence
  // -----------------------------
  // bus and transmit relations
  // -----------------------------
  chk_bus_answer: assert property (s_req |=> WB_ACK_OUT ^ WB_ERR_OUT)
    else $error("request not answered once");
  chk_ack_single: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
    else $error("ack longer than one cycle");
  chk_no_stray: assert property ((WB_ACK_OUT || WB_ERR_OUT) |-> $past(WB_STB_IN))
    else $error("answer without request");
  chk_alias_mapped: assert property ((s_req and in_alias) |=> WB_ACK_OUT)
    else $error("alias word not acked");
  chk_upper_zero: assert property (WB_ACK_OUT && !WB_WE_IN && in_alias |-> WB_DAT_OUT[31:8] == 24'h0)
    else $error("alias upper bits not zero");
  chk_hold_clear: assert property (s_alias_wr |=> !HOLD_EMPTY_OUT)
    else $error("holding empty after write");
  chk_tx_stand: assert property (TX_VALID_OUT && !TX_TAKE_IN |=> TX_VALID_OUT)
    else $error("pending byte vanished");
  chk_tx_taken: assert property (TX_VALID_OUT && TX_TAKE_IN |=> !TX_VALID_OUT)
    else $error("byte not released");
  chk_valid_busy: assert property (TX_VALID_OUT |-> !HOLD_EMPTY_OUT)
    else $error("empty flag with byte pending");
endmodule
bind uart_shadow_data_path uart_shadow_checker u_chk (.REF_CLK_IN, .SRST_IN, .WB_CYC_IN, .WB_STB_IN,
  .WB_WE_IN, .WB_ADR_IN, .WB_SEL_IN, .WB_DAT_OUT, .WB_ACK_OUT, .WB_ERR_OUT, .TX_TAKE_IN,
  .TX_VALID_OUT, .HOLD_EMPTY_OUT);

// ===== sim/uart_tx_sink.sv
`timescale 1ns/1ps
module uart_tx_sink
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        valid_in,
  input  wire logic [7:0]  data_in,
  input  wire logic [15:0] stall_in,
  output logic             take_out
);
  logic [15:0] wait_cnt; // cycles the pending byte has waited
  logic [7:0]  got[$];   // bytes sent on the line, in order
  // serial shifter: takes a byte after stall_in cycles
  always @(posedge clk_in)
    if (rst_in)
    begin
      take_out <= 1'b0;
      wait_cnt <= 16'h0;
    end
    else if (valid_in && take_out)
    begin
      take_out <= 1'b0;
      wait_cnt <= 16'h0;
      got.push_back(data_in);
    end
    else
    begin
      take_out <= valid_in && (wait_cnt >= stall_in);
      wait_cnt <= valid_in ? wait_cnt + 16'h1 : 16'h0;
    end
endmodule

// ===== sim/uart_shadow_data_path_tb_top.sv
`timescale 1ns/1ps
module uart_shadow_data_path_tb_top;
  import uart_shadow_pkg::*;
  logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, e;
  logic [31:0] adr = '0, dat = '0, q;
  logic [3:0]  sel = 4'hf;
  logic [15:0] stall = 16'h0;
  logic [31:0] dout;
  logic [7:0]  tdat;
  logic        ack, berr, take, tvld, tir, drdy, hemp;
  int          err_total = 0, checks = 0;
  always #10 clk = ~clk;
  uart_shadow_data_path dut (.REF_CLK_IN(clk), .SRST_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
    .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(dat), .WB_DAT_OUT(dout),
    .WB_ACK_OUT(ack), .WB_ERR_OUT(berr), .TX_TAKE_IN(take), .TX_VALID_OUT(tvld),
    .TX_DATA_OUT(tdat), .TX_IR_OUT(tir), .DATA_READY_OUT(drdy), .HOLD_EMPTY_OUT(hemp));
  uart_tx_sink sink (.clk_in(clk), .rst_in(rst), .valid_in(tvld), .data_in(tdat),
    .stall_in(stall), .take_out(take));
  // -----------------------------
  // tasks
  // -----------------------------
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // one classic cycle; holds until ack or err is seen
  task automatic wb(input logic w, input logic [31:0] a, d);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    do
    begin
      @(posedge clk);
      n++;
    end while (!(ack === 1'b1 || berr === 1'b1) && n < 20);
    if (n >= 20)
    begin
      err_total++;
      report_and_stop;
    end
    else
    begin
      q = dout;
      e = berr;
      {cyc, stb} <= 2'b00;
    end
  endtask
  task automatic rd(input logic [31:0] a, exp, input string nm);
    wb(1'b0, a, 32'h0);
    chk(nm, q, exp);
  endtask
  task automatic wait_got(input int n);
    for (int i = 0; i < 3000 && sink.got.size() < n; i++)
      @(posedge clk);
    chk("sent_count", sink.got.size(), n);
    if (sink.got.size() < n)
      report_and_stop;
  endtask
  // -----------------------------
  // main sequence
  // -----------------------------
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("hold_empty", hemp, 1);
    rd(SHADOW_LAST_ADDR, 32'h0, "alias_reset");
    rd(STATUS_ADDR, 32'h20, "status_reset");
    // single buffer: receive, overrun
    wb(1'b1, RX_INJECT_ADDR, 32'hffff_ff5a);
    repeat (2) @(posedge clk);
    chk("data_ready", drdy, 1);
    rd(SHADOW_LAST_ADDR, 32'h5a, "rx_byte");
    wb(1'b1, RX_INJECT_ADDR, 32'h11);
    wb(1'b1, RX_INJECT_ADDR, 32'h22);
    rd(STATUS_ADDR, 32'h23, "overrun");
    rd(SHADOW_BASE_ADDR, 32'h22, "rx_replaced");
    repeat (2) @(posedge clk);
    chk("data_ready", drdy, 0);
    $display("test single buffer done");
    // single holder: master writes only while holding-empty is set
    chk("hold_empty", hemp, 1);
    // a write without byte lane 0 is acked but loads nothing
    sel <= 4'he;
    wb(1'b1, SHADOW_LAST_ADDR, 32'h77);
    sel <= 4'hf;
    repeat (2) @(posedge clk);
    chk("lane_ignored", hemp, 1);
    // single holder: replace while stalled
    stall <= 16'd1000;
    wb(1'b1, SHADOW_LAST_ADDR, 32'hab41);
    wb(1'b1, SHADOW_BASE_ADDR + 32'h8, 32'hcd42);
    chk("hold_empty", hemp, 0);
    stall <= 16'h0;
    wait_got(1);
    chk("sent_byte", sink.got[0], 32'h42);
    // transmit queue with infrared mode
    wb(1'b1, CONTROL_ADDR, 32'h3);
    rd(CONTROL_ADDR, 32'h3, "queue_ctrl");
    stall <= 16'd1000;
    for (int i = 0; i < 17; i++)
    begin
      wb(1'b1, SHADOW_BASE_ADDR + 32'(4 * (i % 16)), 32'(8'h80 + i));
      if (i == 14 || i == 15)
        rd(STATUS_ADDR, (i == 15) ? 32'h100 : 32'h0, "tx_full");
    end
    chk("ir_mode", tir, 1);
    stall <= 16'h0;
    wait_got(17);
    repeat (40) @(posedge clk);
    chk("sent_count", sink.got.size(), 17);
    for (int i = 0; i < 16; i++)
      chk("queued_byte", sink.got[i + 1], 32'(8'h80 + i));
    $display("test transmit done");
    // receive queue: fill past full
    for (int i = 0; i < 17; i++)
      wb(1'b1, RX_INJECT_ADDR, 32'(8'h10 + i));
    rd(STATUS_ADDR, 32'h223, "rx_full");
    for (int i = 0; i < 16; i++)
      rd(SHADOW_LAST_ADDR - 32'(4 * i), 32'(8'h10 + i), "rx_queue");
    repeat (2) @(posedge clk);
    chk("data_ready", drdy, 0);
    // unmapped word and mode back to normal
    wb(1'b0, 32'h5000_1190, 32'h0);
    chk("unmapped_err", e, 1);
    wb(1'b1, CONTROL_ADDR, 32'h0);
    repeat (2) @(posedge clk);
    chk("ir_mode", tir, 0);
    $display("test receive done");
    report_and_stop;
  end
  // watchdog
  initial
  begin
    repeat (100000) @(posedge clk);
    err_total++;
    report_and_stop;
  end
endmodule
